// *** hdl/mob_unit.sv ***
/*
  Memory ordering and barrier unit: reservation tracking for
  load-reserve and store-conditional, full barrier with bus broadcast,
  I/O ordering barrier, refetch barrier, and an Avalon-MM register slave.
  Assumes the pipeline, load/store unit and system bus share CLOCK_I.
*/
`timescale 1ns/1ps
`include "mob_defs.svh"

module mob_unit
  import mob_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  // Issue from the pipeline
  input  wire logic        ISSUE_VALID_I,
  input  wire logic [2:0]  ISSUE_OP_I,
  input  wire logic [31:0] ISSUE_EA_I,
  input  wire logic        ISSUE_RC_I,
  input  wire logic        ISSUE_WT_I,
  input  wire logic        XER_SO_I,
  output logic             ISSUE_READY_O,
  // Pipeline and load/store unit progress
  input  wire logic        PRIOR_EXC_CLEAR_I,
  input  wire logic        PRIOR_DONE_I,
  input  wire logic        LSU_IDLE_I,
  input  wire logic        TOUCH_XLAT_DONE_I,
  input  wire logic        IO_IDLE_I,
  input  wire logic        SQ_IO_BAR_I,
  input  wire logic        SNOOP_VALID_I,
  input  wire logic [31:0] SNOOP_ADDR_I,
  // Results
  output logic             HOLD_O,
  output logic             DONE_O,
  output logic             STORE_EN_O,
  output logic             CR0_WE_O,
  output logic [3:0]       CR0_O,
  output logic             DSI_EXC_O,
  output logic             ALIGN_EXC_O,
  output logic             FLUSH_O,
  output logic             GATHER_MERGE_O,
  // System bus barrier broadcast
  output logic             BUS_REQ_O,
  output logic             BUS_KIND_O,
  input  wire logic        BUS_ACK_I,
  input  wire logic        BUS_RETRY_I,
  // Register slave
  input  wire logic [4:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic             AVS_WAITREQUEST_O,
  output logic [31:0]      AVS_READDATA_O,
  output logic             IRQ_O
);

  mob_state_type             state;
  mob_state_type             next_state;
  mob_op_type                cur_op;
  logic                      resv_valid;
  logic [26:0]               resv_blk;
  logic                      ctrl_gather;
  logic                      ctrl_lock;
  logic [`MOB_EV_WIDTH-1:0]  status;
  logic [`MOB_EV_WIDTH-1:0]  irq_en;

  // Issue decode
  wire        accept      = ISSUE_VALID_I & ISSUE_READY_O;
  wire        op_lr       = ISSUE_OP_I == MOB_OP_LOAD_RSV;
  wire        op_sc       = ISSUE_OP_I == MOB_OP_STORE_CND;
  wire        op_atomic   = op_lr | op_sc;
  wire        op_barrier  = (ISSUE_OP_I == MOB_OP_FULL_BAR) |
                            (ISSUE_OP_I == MOB_OP_IO_BAR) |
                            (ISSUE_OP_I == MOB_OP_REFETCH);
  wire [26:0] issue_blk   = ISSUE_EA_I[31:`MOB_RESV_LSB];       // see [RQ1]
  wire        misaligned  = ISSUE_EA_I[1:0] != `MOB_WORD_OFS;

  // Alignment takes priority; no access is made when either fires
  wire        align_fault = accept & op_atomic & misaligned;    // see [RQ3]
  wire        dsi_fault   = accept & op_atomic & ~misaligned &
                            (ISSUE_WT_I | ctrl_lock);          // see [RQ2]
  wire        atom_ok     = accept & op_atomic & ~misaligned &
                            ~ISSUE_WT_I & ~ctrl_lock;
  wire        lr_take     = atom_ok & op_lr;
  wire        sc_take     = atom_ok & op_sc;
  wire        sc_hit      = sc_take & resv_valid &
                            (resv_blk == issue_blk);            // see [RQ5]

  // Forms with the record bit that are invalid: reserve and full barrier
  wire        bad_form    = accept & ISSUE_RC_I &
                            (op_lr | (ISSUE_OP_I == MOB_OP_FULL_BAR)); // see [RQ11]

  // Another agent writing the reserved region kills the reservation
  wire        snoop_kill  = SNOOP_VALID_I & resv_valid &
                            (SNOOP_ADDR_I[31:`MOB_RESV_LSB] == resv_blk);

  // Condition field: eq reports success, so copies the summary overflow.
  // Without the record bit the value is left undefined; zero is written.
  wire [3:0]  sc_cr0      = ISSUE_RC_I ?
                            {1'b0, 1'b0, sc_hit, XER_SO_I} :
                            `MOB_CR0_UNDEF;                    // see [RQ4]
  wire        cr0_write   = sc_take | bad_form;
  wire [3:0]  next_cr0    = sc_take ? sc_cr0 : `MOB_CR0_UNDEF;

  // Drain conditions per barrier kind.
  // Touch prefetches count only through translation, so their bus fills
  // may still be in flight when the full barrier ends.
  wire        full_ready  = PRIOR_EXC_CLEAR_I & LSU_IDLE_I &
                            TOUCH_XLAT_DONE_I;         // see [RQ6] see [RQ7] see [RQ8]
  wire        io_ready    = IO_IDLE_I;                          // see [RQ12]
  // Store queue is deliberately not consulted for the refetch barrier
  wire        ref_ready   = PRIOR_EXC_CLEAR_I &
                            PRIOR_DONE_I;              // see [RQ15] see [RQ16] see [RQ17]
  wire        drain_ok    = (cur_op == MOB_OP_FULL_BAR) ? full_ready :
                            (cur_op == MOB_OP_IO_BAR)   ? io_ready   :
                            ref_ready;
  wire        needs_bus   = cur_op != MOB_OP_REFETCH;

  // Barrier sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      MOB_ST_IDLE: begin
        if (accept & op_barrier) begin
          next_state = MOB_ST_DRAIN;
        end
      end
      MOB_ST_DRAIN: begin
        if (drain_ok) begin
          next_state = needs_bus ? MOB_ST_BCAST : MOB_ST_FINISH;
        end
      end
      MOB_ST_BCAST: begin
        // A retried broadcast goes back and is sent again
        if (BUS_RETRY_I) begin
          next_state = MOB_ST_DRAIN;
        end else if (BUS_ACK_I) begin
          next_state = MOB_ST_FINISH;                           // see [RQ9]
        end
      end
      MOB_ST_FINISH: begin
        next_state = MOB_ST_IDLE;
      end
    endcase
  end

  // Pulses and levels derived from the sequencer
  wire        finishing   = state == MOB_ST_FINISH;
  wire        next_bus    = next_state == MOB_ST_BCAST;         // see [RQ13]
  wire        next_hold   = next_state != MOB_ST_IDLE;          // see [RQ6] see [RQ12]
  wire        next_flush  = finishing & (cur_op == MOB_OP_REFETCH); // see [RQ15] see [RQ18]
  wire        next_done   = finishing | lr_take | sc_take |
                            align_fault | dsi_fault;

  // Merging stays off while an I/O barrier sits in the store queue
  wire        next_merge  = ctrl_gather & ~SQ_IO_BAR_I;         // see [RQ14]

  // Event vector feeding the sticky status bits
  logic [`MOB_EV_WIDTH-1:0] events;
  assign events[`MOB_EV_ALIGN]     = align_fault;
  assign events[`MOB_EV_DSI]       = dsi_fault;
  assign events[`MOB_EV_SC_FAIL]   = sc_take & ~sc_hit;
  assign events[`MOB_EV_FULL_DONE] = finishing & (cur_op == MOB_OP_FULL_BAR);
  assign events[`MOB_EV_IO_DONE]   = finishing & (cur_op == MOB_OP_IO_BAR);
  assign events[`MOB_EV_INVALID]   = bad_form;

  // Register slave decode; one wait cycle then one answer cycle
  wire        bus_req     = AVS_READ_I | AVS_WRITE_I;
  wire        wr_go       = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
  wire [31:0] be_mask     = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                             {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  wire [31:0] wdata       = AVS_WRITEDATA_I & be_mask;
  wire        wr_ctrl     = wr_go & (AVS_ADDRESS_I == `MOB_REG_CTRL);
  wire        wr_en       = wr_go & (AVS_ADDRESS_I == `MOB_REG_IRQ_EN);
  wire        wr_clr      = wr_go & (AVS_ADDRESS_I == `MOB_REG_IRQ_CLR);

  // Byte enables also mask what is kept, not only what is written
  wire [1:0]  ctrl_now    = {ctrl_lock, ctrl_gather};
  wire [1:0]  next_ctrl   = (ctrl_now & ~be_mask[1:0]) | wdata[1:0];
  wire [`MOB_EV_WIDTH-1:0] next_en =
                            (irq_en & ~be_mask[`MOB_EV_WIDTH-1:0]) |
                            wdata[`MOB_EV_WIDTH-1:0];

  // A clear meets a new event: the event wins
  wire [`MOB_EV_WIDTH-1:0] clr_bits =
                            wr_clr ? wdata[`MOB_EV_WIDTH-1:0] : `MOB_EV_RESET;
  wire [`MOB_EV_WIDTH-1:0] next_status = (status & ~clr_bits) | events;

  // Read selection; unmapped and write-only offsets read zero
  wire [31:0] rd_status   = {{(32-`MOB_EV_WIDTH){1'b0}}, status};
  wire [31:0] rd_en       = {{(32-`MOB_EV_WIDTH){1'b0}}, irq_en};
  wire [31:0] rd_ctrl     = {30'h0, ctrl_lock, ctrl_gather};
  wire [31:0] rd_resv     = {resv_blk, 4'h0, resv_valid};
  wire [31:0] next_rdata  =
    (AVS_ADDRESS_I == `MOB_REG_CTRL)   ? rd_ctrl   :
    (AVS_ADDRESS_I == `MOB_REG_STATUS) ? rd_status :
    (AVS_ADDRESS_I == `MOB_REG_IRQ_EN) ? rd_en     :
    (AVS_ADDRESS_I == `MOB_REG_RESV)   ? rd_resv   : 32'h0;

  wire        next_irq    = |(next_status & (wr_en ? next_en : irq_en));

  // Sequencer, operation, pipeline-facing and bus broadcast outputs
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      state          <= MOB_ST_IDLE;
      cur_op         <= MOB_OP_NONE;
      ISSUE_READY_O  <= 1'b0;
      HOLD_O         <= 1'b0;
      DONE_O         <= 1'b0;
      FLUSH_O        <= 1'b0;
      BUS_REQ_O      <= 1'b0;
      BUS_KIND_O     <= MOB_BUS_FULL;
    end else begin
      state          <= next_state;
      if (accept & op_barrier) begin
        cur_op       <= mob_op_type'(ISSUE_OP_I);
      end
      ISSUE_READY_O  <= ~next_hold;
      HOLD_O         <= next_hold;
      DONE_O         <= next_done;
      FLUSH_O        <= next_flush;
      BUS_REQ_O      <= next_bus;
      BUS_KIND_O     <= (cur_op == MOB_OP_IO_BAR) ? MOB_BUS_IO : MOB_BUS_FULL;
    end
  end

  // Reservation and atomic results
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      resv_valid     <= 1'b0;
      resv_blk       <= 27'h0;
      STORE_EN_O     <= 1'b0;
      CR0_WE_O       <= 1'b0;
      CR0_O          <= `MOB_CR0_UNDEF;
      DSI_EXC_O      <= 1'b0;
      ALIGN_EXC_O    <= 1'b0;
    end else begin
      if (lr_take) begin
        resv_valid   <= 1'b1;                                   // see [RQ1]
        resv_blk     <= issue_blk;
      end else if (sc_take | snoop_kill) begin
        resv_valid   <= 1'b0;                                   // see [RQ5]
      end
      STORE_EN_O     <= sc_hit;                                 // see [RQ5]
      CR0_WE_O       <= cr0_write;
      CR0_O          <= next_cr0;
      DSI_EXC_O      <= dsi_fault;
      ALIGN_EXC_O    <= align_fault;
    end
  end

  // Software registers, interrupt and store gathering control
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      {ctrl_lock, ctrl_gather} <= `MOB_CTRL_RESET;
      irq_en         <= `MOB_EV_RESET;
      status         <= `MOB_EV_RESET;
      IRQ_O          <= 1'b0;
      GATHER_MERGE_O <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        {ctrl_lock, ctrl_gather} <= next_ctrl;
      end
      if (wr_en) begin
        irq_en       <= next_en;
      end
      status         <= next_status;
      IRQ_O          <= next_irq;
      GATHER_MERGE_O <= next_merge;
    end
  end

  // Avalon handshake: waitrequest drops for exactly one cycle per access
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h0;
    end else begin
      AVS_WAITREQUEST_O <= ~(bus_req & AVS_WAITREQUEST_O);
      if (AVS_READ_I & AVS_WAITREQUEST_O) begin
        AVS_READDATA_O  <= next_rdata;
      end
    end
  end

endmodule : mob_unit

// *** pkg/mob_defs.svh ***
/*
  Constants of the memory ordering and barrier unit: register offsets,
  field positions, reset values and encodings.
  Assumes it is included by its bare name from the package and the design.
*/
// How it works
// [RQ1] Reservation covers one aligned 32-byte region
// [RQ2] Write-through page or locked cache raises DSI
// [RQ3] Unaligned reserve or conditional raises alignment exception
// [RQ4] Conditional store valid with record bit; else undefined
// [RQ5] Conditional store needs matching reservation, then clears
// [RQ6] Full barrier holds later instructions past exception point
// [RQ7] Full barrier waits for earlier load/store/bus work
// [RQ8] Touch prefetches need only finish translation
// [RQ9] Full barrier completes after successful bus broadcast
// [RQ10] External caches finish queued references before acknowledging
// [RQ11] Barrier or reserve with record bit: undefined field
// [RQ12] I/O barrier waits for earlier uncached/write-through accesses
// [RQ13] I/O barrier skips caches, broadcast on external bus
// [RQ14] No store merging across queued I/O barrier
// [RQ15] Refetch barrier waits, flushes, refetches next instruction
// [RQ16] Refetch barrier waits for earlier exception point
// [RQ17] Refetch barrier does not wait for store drain
// [RQ18] Later fetches see all earlier effects
`ifndef MOB_DEFS_SVH
`define MOB_DEFS_SVH

// Register byte offsets
`define MOB_REG_CTRL      5'h00
`define MOB_REG_STATUS    5'h04
`define MOB_REG_IRQ_EN    5'h08
`define MOB_REG_IRQ_CLR   5'h0c
`define MOB_REG_RESV      5'h10

// Control register fields
`define MOB_CTRL_GATHER   0
`define MOB_CTRL_LOCK     1
`define MOB_CTRL_RESET    2'h0

// Status, enable and clear layout
`define MOB_EV_ALIGN      0
`define MOB_EV_DSI        1
`define MOB_EV_SC_FAIL    2
`define MOB_EV_FULL_DONE  3
`define MOB_EV_IO_DONE    4
`define MOB_EV_INVALID    5
`define MOB_EV_WIDTH      6
`define MOB_EV_RESET      6'h00

// Reservation register: region in 31:5, valid flag in bit 0
`define MOB_RESV_LSB      5
`define MOB_RESV_VALID    0

// Condition field encodings (lt, gt, eq, so)
`define MOB_CR0_UNDEF     4'h0
`define MOB_CR0_EQ        1

// Word alignment check
`define MOB_WORD_OFS      2'h0

`endif

// *** pkg/mob_pkg.sv ***
/*
  Types of the memory ordering and barrier unit.
  Assumes mob_defs.svh supplies the numeric constants.
*/
`include "mob_defs.svh"

package mob_pkg;

  // Operations issued by the pipeline
  typedef enum logic [2:0] {
    MOB_OP_NONE      = 3'h0,
    MOB_OP_LOAD_RSV  = 3'h1,
    MOB_OP_STORE_CND = 3'h2,
    MOB_OP_FULL_BAR  = 3'h3,
    MOB_OP_IO_BAR    = 3'h4,
    MOB_OP_REFETCH   = 3'h5
  } mob_op_type;

  // Barrier sequencer states
  typedef enum logic [1:0] {
    MOB_ST_IDLE   = 2'h0,
    MOB_ST_DRAIN  = 2'h1,
    MOB_ST_BCAST  = 2'h2,
    MOB_ST_FINISH = 2'h3
  } mob_state_type;

  // Kind of barrier transaction on the system bus
  typedef enum logic {
    MOB_BUS_FULL = 1'b0,
    MOB_BUS_IO   = 1'b1
  } mob_bus_type;

endpackage : mob_pkg

// *** verification/mob_bus_agent.sv ***
/*
  System bus agent that answers barrier broadcasts.
  Assumes the request stays high until an answer is seen.
*/
`timescale 1ns/1ps

module mob_bus_agent (
  input  wire logic       clock_i,
  input  wire logic       req_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       retry_i,
  output logic            ack_o,
  output logic            retry_o
);
  logic [3:0] wait_cnt;
  logic       answered;

  // One answer per request; the delay stands for queued work finishing first
  always @(posedge clock_i) begin
    ack_o   <= 1'b0;
    retry_o <= 1'b0;
    if (!req_i) begin
      wait_cnt <= 4'h0;
      answered <= 1'b0;
    end else if (!answered && wait_cnt == delay_i) begin
      ack_o    <= !retry_i;
      retry_o  <= retry_i;
      answered <= 1'b1;
    end else if (!answered) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : mob_bus_agent

// *** verification/mob_unit_assertions.sv ***
/*
  Port checker for mob_unit, bound to every instance of it.
  Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "mob_defs.svh"

module mob_unit_chk
  import mob_pkg::*;
(
  input wire logic        CLOCK_I,
  input wire logic        RESETN_I,
  input wire logic        ISSUE_VALID_I,
  input wire logic [2:0]  ISSUE_OP_I,
  input wire logic [31:0] ISSUE_EA_I,
  input wire logic        ISSUE_RC_I,
  input wire logic        ISSUE_WT_I,
  input wire logic        ISSUE_READY_O,
  input wire logic        LSU_IDLE_I,
  input wire logic        IO_IDLE_I,
  input wire logic        SQ_IO_BAR_I,
  input wire logic        HOLD_O,
  input wire logic        DONE_O,
  input wire logic        STORE_EN_O,
  input wire logic [3:0]  CR0_O,
  input wire logic        DSI_EXC_O,
  input wire logic        ALIGN_EXC_O,
  input wire logic        FLUSH_O,
  input wire logic        GATHER_MERGE_O,
  input wire logic        BUS_REQ_O,
  input wire logic        BUS_KIND_O,
  input wire logic        BUS_ACK_I,
  input wire logic        BUS_RETRY_I
);
  // Accepted reserve or conditional store
  wire acc_atom = ISSUE_VALID_I && ISSUE_READY_O &&
                  (ISSUE_OP_I == MOB_OP_LOAD_RSV || ISSUE_OP_I == MOB_OP_STORE_CND);

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  AST_ALIGN: assert property (
    acc_atom && ISSUE_EA_I[1:0] != 2'h0 |=> ALIGN_EXC_O && !STORE_EN_O) else $error("no align");
  AST_DSI: assert property (
    acc_atom && ISSUE_EA_I[1:0] == 2'h0 && ISSUE_WT_I |=> DSI_EXC_O && !STORE_EN_O)
    else $error("no dsi");
  AST_SC_OK: assert property (
    STORE_EN_O && $past(ISSUE_RC_I) |-> CR0_O[`MOB_CR0_EQ]) else $error("eq not set");
  AST_HOLD: assert property (
    HOLD_O |-> !ISSUE_READY_O) else $error("issue open while held");
  AST_FULL_DRAIN: assert property (
    $rose(BUS_REQ_O) && BUS_KIND_O == MOB_BUS_FULL |-> $past(LSU_IDLE_I))
    else $error("full broadcast before drain");
  AST_IO_DRAIN: assert property (
    $rose(BUS_REQ_O) && BUS_KIND_O == MOB_BUS_IO |-> $past(IO_IDLE_I))
    else $error("io broadcast before drain");
  AST_ACK_DONE: assert property (
    BUS_REQ_O && BUS_ACK_I |=> !BUS_REQ_O ##1 DONE_O) else $error("no done after ack");
  AST_RETRY: assert property (
    BUS_REQ_O && BUS_RETRY_I |=> !BUS_REQ_O && !DONE_O) else $error("retry ignored");
  AST_BUS_STEADY: assert property (
    BUS_REQ_O && !BUS_ACK_I && !BUS_RETRY_I |=> BUS_REQ_O && $stable(BUS_KIND_O))
    else $error("broadcast dropped");
  AST_FLUSH: assert property (
    FLUSH_O |-> DONE_O && !BUS_REQ_O) else $error("flush without done");
  AST_GATHER: assert property (
    SQ_IO_BAR_I && $past(SQ_IO_BAR_I) |-> !GATHER_MERGE_O) else $error("merge across io");

  // Main scenarios reached
  COV_FLUSH: cover property (FLUSH_O);
  COV_RETRY: cover property (BUS_REQ_O && BUS_RETRY_I);
  COV_STORE: cover property (STORE_EN_O);
endmodule : mob_unit_chk

bind mob_unit mob_unit_chk u_chk (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I),
  .ISSUE_VALID_I(ISSUE_VALID_I), .ISSUE_OP_I(ISSUE_OP_I), .ISSUE_EA_I(ISSUE_EA_I),
  .ISSUE_RC_I(ISSUE_RC_I), .ISSUE_WT_I(ISSUE_WT_I), .ISSUE_READY_O(ISSUE_READY_O),
  .LSU_IDLE_I(LSU_IDLE_I), .IO_IDLE_I(IO_IDLE_I), .SQ_IO_BAR_I(SQ_IO_BAR_I),
  .HOLD_O(HOLD_O), .DONE_O(DONE_O), .STORE_EN_O(STORE_EN_O), .CR0_O(CR0_O),
  .DSI_EXC_O(DSI_EXC_O), .ALIGN_EXC_O(ALIGN_EXC_O), .FLUSH_O(FLUSH_O),
  .GATHER_MERGE_O(GATHER_MERGE_O), .BUS_REQ_O(BUS_REQ_O), .BUS_KIND_O(BUS_KIND_O),
  .BUS_ACK_I(BUS_ACK_I), .BUS_RETRY_I(BUS_RETRY_I));

// *** verification/testbench.sv ***
/*
  Self-checking bench for mob_unit.
  Assumes mob_bus_agent answers the barrier broadcasts.
*/
`timescale 1ns/1ps
`include "mob_defs.svh"

module testbench
  import mob_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, iv = 1'b0, rc = 1'b0, wt = 1'b0, so = 1'b0;
  logic        exc = 1'b1, pd = 1'b1, load_store_unit = 1'b1, tch = 1'b1, io = 1'b1, sq = 1'b0;
  logic        sn = 1'b0, rd = 1'b0, wr = 1'b0, agt_retry = 1'b0;
  logic [2:0]  op = 3'h0;
  logic [3:0]  be = 4'hf, agt_dly = 4'h3;
  logic [4:0]  adr = 5'h0;
  logic [31:0] ea = 32'h0, saddr = 32'h0, wd = 32'h0, rdv;
  logic [7:0]  res;
  logic        rdy, hold, done, sten, crwe, dsi, aln, flush, gm, breq, bkind, back, bretry;
  logic        wreq, irq;
  logic [3:0]  cr0;
  logic [31:0] rdd;
  int          mismatches = 0, cmp_count = 0;

  // Core clock at 20 MHz
  always #25 clk = ~clk;

  mob_unit DUT (.CLOCK_I(clk), .RESETN_I(rst_n), .ISSUE_VALID_I(iv), .ISSUE_OP_I(op),
    .ISSUE_EA_I(ea), .ISSUE_RC_I(rc), .ISSUE_WT_I(wt), .XER_SO_I(so), .ISSUE_READY_O(rdy),
    .PRIOR_EXC_CLEAR_I(exc), .PRIOR_DONE_I(pd), .LSU_IDLE_I(load_store_unit), .TOUCH_XLAT_DONE_I(tch),
    .IO_IDLE_I(io), .SQ_IO_BAR_I(sq), .SNOOP_VALID_I(sn), .SNOOP_ADDR_I(saddr),
    .HOLD_O(hold), .DONE_O(done), .STORE_EN_O(sten), .CR0_WE_O(crwe), .CR0_O(cr0),
    .DSI_EXC_O(dsi), .ALIGN_EXC_O(aln), .FLUSH_O(flush), .GATHER_MERGE_O(gm),
    .BUS_REQ_O(breq), .BUS_KIND_O(bkind), .BUS_ACK_I(back), .BUS_RETRY_I(bretry),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_BYTEENABLE_I(be), .AVS_WAITREQUEST_O(wreq), .AVS_READDATA_O(rdd), .IRQ_O(irq));

  mob_bus_agent u_agent (.clock_i(clk), .req_i(breq), .delay_i(agt_dly),
    .retry_i(agt_retry), .ack_o(back), .retry_o(bretry));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk

  // One register access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr  <= w;
    rd  <= !w;
    adr <= a;
    wd  <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    rdv = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rchk

  // Issue one op; result pulses are caught one cycle after acceptance
  task automatic iss(input mob_op_type o, input logic [31:0] a, input logic r, input logic w);
    @(posedge clk);
    iv <= 1'b1;
    op <= o;
    ea <= a;
    rc <= r;
    wt <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    iv <= 1'b0;
    // Pulses launched at the accepting edge are read at the next one
    @(posedge clk);
    res = {aln, dsi, sten, crwe, cr0};
  endtask : iss

  task automatic wdone;
    for (int n = 0; n < 200 && done !== 1'b1; n++) @(posedge clk);
  endtask : wdone

  // Reset values, unmapped place, read-only status
  task automatic t_regs;
    rchk(`MOB_REG_CTRL, 32'h0);
    rchk(5'h14, 32'h0);
    bus(1'b1, `MOB_REG_STATUS, 32'hff);
    rchk(`MOB_REG_STATUS, 32'h0);
  endtask : t_regs

  // Granule, success, failure, snoop kill
  task automatic t_resv;
    iss(MOB_OP_LOAD_RSV, 32'h100, 1'b0, 1'b0);
    rchk(`MOB_REG_RESV, 32'h101);
    so <= 1'b1;
    iss(MOB_OP_STORE_CND, 32'h11c, 1'b1, 1'b0);
    chk(res, {4'h3, (4'h1 << `MOB_CR0_EQ) | 4'h1});
    so <= 1'b0;
    iss(MOB_OP_STORE_CND, 32'h11c, 1'b1, 1'b0);
    chk(res, {4'h1, 4'h0});
    iss(MOB_OP_LOAD_RSV, 32'h100, 1'b0, 1'b0);
    iss(MOB_OP_STORE_CND, 32'h120, 1'b0, 1'b0);
    chk(res[7:4], 4'h1);
    iss(MOB_OP_LOAD_RSV, 32'h100, 1'b0, 1'b0);
    iss(MOB_OP_STORE_CND, 32'h104, 1'b0, 1'b0);
    chk(res, {4'h3, 4'h0});
    iss(MOB_OP_LOAD_RSV, 32'h100, 1'b0, 1'b0);
    sn    <= 1'b1;
    saddr <= 32'h118;
    @(posedge clk);
    sn <= 1'b0;
    iss(MOB_OP_STORE_CND, 32'h100, 1'b0, 1'b0);
    chk(res[7:4], 4'h1);
  endtask : t_resv

  // Alignment before write-through, locked cache
  task automatic t_exc;
    iss(MOB_OP_LOAD_RSV, 32'h102, 1'b0, 1'b0);
    chk(res[7:5], 3'h4);
    iss(MOB_OP_STORE_CND, 32'h201, 1'b1, 1'b1);
    chk(res[7:5], 3'h4);
    iss(MOB_OP_LOAD_RSV, 32'h200, 1'b0, 1'b1);
    chk(res[7:5], 3'h2);
    bus(1'b1, `MOB_REG_CTRL, 32'h2);
    iss(MOB_OP_STORE_CND, 32'h200, 1'b1, 1'b0);
    chk(res[7:5], 3'h2);
    bus(1'b1, `MOB_REG_CTRL, 32'h0);
    rchk(`MOB_REG_STATUS, 32'h7);
  endtask : t_exc

  // Interrupt raised, masked and cleared
  task automatic t_irq;
    bus(1'b1, `MOB_REG_IRQ_EN, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    bus(1'b1, `MOB_REG_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    bus(1'b1, `MOB_REG_IRQ_EN, 32'h2);
    bus(1'b1, `MOB_REG_IRQ_CLR, 32'h3f);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rchk(`MOB_REG_STATUS, 32'h0);
  endtask : t_irq

  // Full barrier held by drain and touches, retried once, invalid form
  task automatic t_full;
    load_store_unit       <= 1'b0;
    tch       <= 1'b0;
    agt_retry <= 1'b1;
    iss(MOB_OP_FULL_BAR, 32'h0, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
    chk({hold, rdy, breq}, 3'h4);
    load_store_unit <= 1'b1;
    repeat (6) @(posedge clk);
    chk(breq, 1'b0);
    tch <= 1'b1;
    while (bretry !== 1'b1) @(posedge clk);
    agt_retry <= 1'b0;
    wdone();
    chk({done, flush, hold}, 3'h4);
    rchk(`MOB_REG_STATUS, 32'h28);
  endtask : t_full

  // I/O barrier waits for uncached traffic, broadcast kind
  task automatic t_io;
    bus(1'b1, `MOB_REG_IRQ_CLR, 32'h3f);
    io      <= 1'b0;
    agt_dly <= 4'h0;
    iss(MOB_OP_IO_BAR, 32'h0, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    chk({hold, breq}, 2'h2);
    io <= 1'b1;
    while (breq !== 1'b1) @(posedge clk);
    chk(bkind, MOB_BUS_IO);
    wdone();
    chk(done, 1'b1);
    rchk(`MOB_REG_STATUS, 32'h10);
  endtask : t_io

  // Refetch barrier: waits for exception point, not for stores
  task automatic t_fetch;
    load_store_unit <= 1'b0;
    exc <= 1'b0;
    iss(MOB_OP_REFETCH, 32'h0, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    chk({done, flush, hold}, 3'h1);
    exc <= 1'b1;
    wdone();
    chk({done, flush, breq}, 3'h6);
    load_store_unit <= 1'b1;
  endtask : t_fetch

  // Merging stops while an I/O barrier sits in the store queue
  task automatic t_gather;
    bus(1'b1, `MOB_REG_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    chk(gm, 1'b1);
    sq <= 1'b1;
    repeat (2) @(posedge clk);
    chk(gm, 1'b0);
    sq <= 1'b0;
  endtask : t_gather

  task automatic finish_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_resv();
    t_exc();
    t_irq();
    t_full();
    t_io();
    t_fetch();
    t_gather();
    finish_test();
  end

  // Hang guard at 20000 cycles, well beyond the few hundred cycles the run needs
  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end
endmodule : testbench
